//--- pkg/psc_regs.svh
/*
  Constants for the phase shedding controller: command codes, pages,
  field positions, reset values and timing.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// Command codes
`define PSC_CMD_RAMP_CFG 8'hDE
`define PSC_CMD_THR_CFG 8'hDF

// Pages
`define PSC_PAGE_A 8'h00
`define PSC_PAGE_B 8'h01

// shed_ramp_config fields
`define PSC_RAMP_EN_BIT 7
`define PSC_RAMP_DROP_3TO2_LSB 8
`define PSC_RAMP_DROP_4TO3_LSB 10
`define PSC_RAMP_DROP_5TO4_LSB 12
`define PSC_RAMP_DROP_6TO5_LSB 14

// shed_threshold_config fields
`define PSC_THR_PEAK_SEL_LSB 0
`define PSC_THR_ADD_1TO2_LSB 3
`define PSC_THR_ADD_2TO3_LSB 5
`define PSC_THR_ADD_3TO4_LSB 7
`define PSC_THR_ADD_4TO5_LSB 9
`define PSC_THR_ADD_5TO6_LSB 11
`define PSC_THR_DROP_2TO1_LSB 13

// Reset values
`define PSC_RAMP_RST 16'h5580
`define PSC_THR_RST 16'h2AAB

// Threshold arithmetic, amperes
`define PSC_PEAK_EFF_BASE_A 12'h006
`define PSC_PEAK_EFF_STEP_A 12'h002
`define PSC_ADD_OFF_BASE_A 12'h006
`define PSC_FINE_STEP_A 12'h002
`define PSC_DROP_BIAS_A 12'h002

// Drop delay
`define PSC_CLK_MHZ 250
`define PSC_DROP_DELAY_NS 85000
`define PSC_DROP_DELAY_CYC ((`PSC_DROP_DELAY_NS * `PSC_CLK_MHZ) / 1000)

`endif

//--- pkg/psc_pkg.sv
/*
  Types for the phase shedding controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package psc_pkg;
  typedef logic [9:0] psc_amp_t;
  typedef logic [2:0] psc_cnt_t;
  typedef logic [15:0] psc_word_t;
  typedef logic [5:0] psc_mask_t;
endpackage : psc_pkg
`default_nettype wire

//--- hw/psc_shed_ctrl.sv
/*
  Two-channel dynamic phase shedding controller with its paged
  configuration words, reached by a decoded PMBus command port.
  Assumes a PMBus front end that presents one decoded transaction per
  cmd_valid_i pulse, and current sense in whole amperes, synchronous to clk_i.
*/
// Contract
// - Each channel picks its own active phase count from its own current.
// - With shedding disabled every channel runs its maximum phase count.
// - The enable bit set to one turns automatic add and drop on.
// - A phase is added at once when peak current reaches the add threshold.
// - A phase is dropped only after average current stays low for 85 us.
// - Phases turn on in ascending order and off in descending order.
// - A select field sets the per-phase peak-efficiency current for all thresholds.
// - Add threshold n to n+1 is n times peak-efficiency current plus 6 to 12 A.
// - An 8 A two-to-three offset adds phase three at twice peak-efficiency plus 8 A.
// - Drop threshold is the lower count times peak-efficiency plus -2 to +4 A.
// - A zero three-to-two offset drops phase three below twice peak-efficiency.
// - The ramp configuration word also holds ramp and dynamic ramp levels.
// - Page 00h addresses channel A and page 01h channel B.
`include "psc_regs.svh"
`default_nettype none
module psc_shed_ctrl #(
  parameter int DROP_DELAY_CYC = `PSC_DROP_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_word_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] page_i,
  input wire psc_pkg::psc_word_t wdata_i,
  input wire psc_pkg::psc_amp_t peak_cur_a_i,
  input wire psc_pkg::psc_amp_t avg_cur_a_i,
  input wire psc_pkg::psc_cnt_t max_phases_a_i,
  input wire psc_pkg::psc_amp_t peak_cur_b_i,
  input wire psc_pkg::psc_amp_t avg_cur_b_i,
  input wire psc_pkg::psc_cnt_t max_phases_b_i,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output psc_pkg::psc_word_t rdata_o,
  output psc_pkg::psc_mask_t phase_en_a_o,
  output psc_pkg::psc_mask_t phase_en_b_o,
  output psc_pkg::psc_word_t ramp_cfg_a_o,
  output psc_pkg::psc_word_t ramp_cfg_b_o
);
  import psc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Threshold functions

  function automatic logic [11:0] peak_eff(input logic [2:0] sel);
    return `PSC_PEAK_EFF_BASE_A + 12'(sel) * `PSC_PEAK_EFF_STEP_A;
  endfunction : peak_eff

  function automatic logic [1:0] add_code(input psc_word_t thr, input psc_cnt_t n);
    case (n)
      3'd1: return thr[`PSC_THR_ADD_1TO2_LSB +: 2];
      3'd2: return thr[`PSC_THR_ADD_2TO3_LSB +: 2];
      3'd3: return thr[`PSC_THR_ADD_3TO4_LSB +: 2];
      3'd4: return thr[`PSC_THR_ADD_4TO5_LSB +: 2];
      default: return thr[`PSC_THR_ADD_5TO6_LSB +: 2];
    endcase
  endfunction : add_code

  function automatic logic [1:0] drop_code(input psc_word_t rmp, input psc_word_t thr,
                                           input psc_cnt_t n);
    case (n)
      3'd2: return thr[`PSC_THR_DROP_2TO1_LSB +: 2];
      3'd3: return rmp[`PSC_RAMP_DROP_3TO2_LSB +: 2];
      3'd4: return rmp[`PSC_RAMP_DROP_4TO3_LSB +: 2];
      3'd5: return rmp[`PSC_RAMP_DROP_5TO4_LSB +: 2];
      default: return rmp[`PSC_RAMP_DROP_6TO5_LSB +: 2];
    endcase
  endfunction : drop_code

  // n * ieff + 6 + 2 * code
  function automatic logic [11:0] add_thr(input psc_word_t thr, input psc_cnt_t n);
    return 12'(n) * peak_eff(thr[`PSC_THR_PEAK_SEL_LSB +: 3])
           + `PSC_ADD_OFF_BASE_A + 12'(add_code(thr, n)) * `PSC_FINE_STEP_A;
  endfunction : add_thr

  // (n-1) * ieff + 2 * code, biased by +2 A so the -2 A step stays unsigned
  function automatic logic [11:0] drop_thr_b(input psc_word_t rmp, input psc_word_t thr,
                                             input psc_cnt_t n);
    return 12'(n - 3'd1) * peak_eff(thr[`PSC_THR_PEAK_SEL_LSB +: 3])
           + 12'(drop_code(rmp, thr, n)) * `PSC_FINE_STEP_A;
  endfunction : drop_thr_b

  function automatic psc_mask_t cnt_mask(input psc_cnt_t n);
    return psc_mask_t'((7'h01 << n) - 7'h01);
  endfunction : cnt_mask

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  psc_word_t ramp_ff [2];
  psc_word_t thr_ff [2];
  psc_word_t nxt_ramp [2];
  psc_word_t nxt_thr [2];
  logic rsp_valid_ff;
  logic rsp_err_ff;
  psc_word_t rdata_ff;
  logic nxt_rsp_valid;
  logic nxt_rsp_err;
  psc_word_t nxt_rdata;
  logic page_ok;
  logic code_ok;
  logic ch;

  always_comb begin
    page_ok = (page_i == `PSC_PAGE_A) || (page_i == `PSC_PAGE_B);
    ch = (page_i == `PSC_PAGE_B);
    code_ok = (cmd_code_i == `PSC_CMD_RAMP_CFG) || (cmd_code_i == `PSC_CMD_THR_CFG);
    nxt_ramp = ramp_ff;
    nxt_thr = thr_ff;
    nxt_rsp_valid = cmd_valid_i;
    nxt_rsp_err = 1'b0;
    nxt_rdata = 16'h0000;
    if (cmd_valid_i) begin
      if (!page_ok || !code_ok || !cmd_word_i) begin
        nxt_rsp_err = 1'b1;
      end else if (cmd_write_i) begin
        if (cmd_code_i == `PSC_CMD_RAMP_CFG) begin
          nxt_ramp[ch] = wdata_i;
        end else begin
          nxt_thr[ch] = wdata_i;
        end
      end else begin
        nxt_rdata = (cmd_code_i == `PSC_CMD_RAMP_CFG) ? ramp_ff[ch] : thr_ff[ch];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ramp_ff <= '{`PSC_RAMP_RST, `PSC_RAMP_RST};
      thr_ff <= '{`PSC_THR_RST, `PSC_THR_RST};
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      ramp_ff <= nxt_ramp;
      thr_ff <= nxt_thr;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_err_ff <= nxt_rsp_err;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel phase count

  psc_amp_t peak_cur [2];
  psc_amp_t avg_cur [2];
  psc_cnt_t max_ph [2];
  psc_cnt_t cnt_ff [2];
  psc_cnt_t nxt_cnt [2];
  logic [14:0] tmr_ff [2];
  logic [14:0] nxt_tmr [2];
  psc_mask_t en_ff [2];
  psc_mask_t nxt_en [2];

  always_comb begin
    peak_cur[0] = peak_cur_a_i;
    peak_cur[1] = peak_cur_b_i;
    avg_cur[0] = avg_cur_a_i;
    avg_cur[1] = avg_cur_b_i;
    max_ph[0] = max_phases_a_i;
    max_ph[1] = max_phases_b_i;
    for (int c = 0; c < 2; c++) begin
      nxt_cnt[c] = cnt_ff[c];
      nxt_tmr[c] = 15'h0000;
      if (!ramp_ff[c][`PSC_RAMP_EN_BIT] || cnt_ff[c] > max_ph[c]) begin
        nxt_cnt[c] = max_ph[c];
      end else if (cnt_ff[c] < max_ph[c] && 12'(peak_cur[c]) >= add_thr(thr_ff[c], cnt_ff[c]))
      begin
        nxt_cnt[c] = cnt_ff[c] + 3'd1;
      end else if (cnt_ff[c] > 3'd1 && 12'(avg_cur[c]) + `PSC_DROP_BIAS_A
                   < drop_thr_b(ramp_ff[c], thr_ff[c], cnt_ff[c])) begin
        nxt_tmr[c] = tmr_ff[c] + 15'h0001;
        if (32'(tmr_ff[c]) >= DROP_DELAY_CYC - 1) begin
          nxt_cnt[c] = cnt_ff[c] - 3'd1;
          nxt_tmr[c] = 15'h0000;
        end
      end
      nxt_en[c] = cnt_mask(nxt_cnt[c]); // timer cleared above when not low
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= '{3'd1, 3'd1};
      tmr_ff <= '{15'h0000, 15'h0000};
      en_ff <= '{6'h01, 6'h01};
    end else begin
      cnt_ff <= nxt_cnt;
      tmr_ff <= nxt_tmr;
      en_ff <= nxt_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    rsp_valid_o = rsp_valid_ff;
    rsp_err_o = rsp_err_ff;
    rdata_o = rdata_ff;
    phase_en_a_o = en_ff[0];
    phase_en_b_o = en_ff[1];
    ramp_cfg_a_o = ramp_ff[0];
    ramp_cfg_b_o = ramp_ff[1];
  end

endmodule : psc_shed_ctrl
`default_nettype wire

//--- dv/psc_shed_sva.sv
/*
  Checker on the ports of psc_shed_ctrl: register port and channel A.
  Assumes a drop delay well below any test gap.
*/
`default_nettype none
module psc_shed_sva (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_word_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] page_i,
  input wire psc_pkg::psc_word_t wdata_i,
  input wire psc_pkg::psc_amp_t peak_cur_a_i,
  input wire psc_pkg::psc_amp_t avg_cur_a_i,
  input wire psc_pkg::psc_cnt_t max_phases_a_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_err_o,
  input wire psc_pkg::psc_word_t rdata_o,
  input wire psc_pkg::psc_mask_t phase_en_a_o,
  input wire psc_pkg::psc_word_t ramp_cfg_a_o
);
  import psc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic wr_a;
  logic en_a;
  psc_mask_t full_a;
  assign wr_a = cmd_valid_i && cmd_write_i && cmd_word_i && cmd_code_i == 8'hDE && page_i == 8'h00;
  assign en_a = ramp_cfg_a_o[7];
  assign full_a = psc_mask_t'((7'h01 << max_phases_a_i) - 7'h01);
  a_rsp_next: assert property (cmd_valid_i |=> rsp_valid_o) else $error("no answer");
  a_rsp_cause: assert property (rsp_valid_o |-> $past(cmd_valid_i)) else $error("stray answer");
  a_byte_refused: assert property (cmd_valid_i && !cmd_word_i |=> rsp_err_o && rdata_o == 16'h0000)
    else $error("byte taken");
  a_page_refused: assert property (cmd_valid_i && page_i > 8'h01 |=> rsp_err_o)
    else $error("page taken");
  a_ramp_write: assert property (wr_a |=> ramp_cfg_a_o == $past(wdata_i)) else $error("no write");
  a_chan_isolated: assert property (cmd_valid_i && page_i == 8'h01 |=> $stable(ramp_cfg_a_o))
    else $error("page leak");
  a_mask_order: assert property (((phase_en_a_o + 6'h01) & phase_en_a_o) == 6'h00)
    else $error("mask gap");
  a_full_off: assert property (!en_a |=> phase_en_a_o == $past(full_a)) else $error("not max");
  a_add_now: assert property (en_a && peak_cur_a_i >= 10'd200 && phase_en_a_o < full_a
    |=> phase_en_a_o == psc_mask_t'({$past(phase_en_a_o), 1'b1})) else $error("no add");
  a_hold_high: assert property (en_a && avg_cur_a_i >= 10'd200 && phase_en_a_o <= full_a
    |=> phase_en_a_o >= $past(phase_en_a_o)) else $error("early drop");
  c_add: cover property ($rose(phase_en_a_o[2]));
  c_drop: cover property ($fell(phase_en_a_o[2]));
  c_err: cover property (rsp_valid_o && rsp_err_o);
endmodule : psc_shed_sva
bind psc_shed_ctrl psc_shed_sva u_sva (.clk_i, .sys_rst_i, .cmd_valid_i, .cmd_write_i,
  .cmd_word_i, .cmd_code_i, .page_i, .wdata_i, .peak_cur_a_i, .avg_cur_a_i, .max_phases_a_i,
  .rsp_valid_o, .rsp_err_o, .rdata_o, .phase_en_a_o, .ramp_cfg_a_o);
`default_nettype wire

//--- dv/psc_host_model.sv
/*
  Host model: one decoded PMBus transaction at a time.
  Assumes the answer one cycle after the request.
*/
`default_nettype none
module psc_host_model (
  input wire logic clk_i,
  input wire logic rsp_valid_i,
  input wire logic rsp_err_i,
  input wire psc_pkg::psc_word_t rdata_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic cmd_word_o,
  output logic [7:0] cmd_code_o,
  output logic [7:0] page_o,
  output psc_pkg::psc_word_t wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  initial {cmd_valid_o, cmd_write_o, cmd_word_o, cmd_code_o, page_o, wdata_o} = '0;
  task automatic xfer(input logic w, d, input logic [7:0] c, p, input psc_word_t wd,
                      output psc_word_t rd, output logic err);
    @(negedge clk_i);
    {cmd_valid_o, cmd_write_o, cmd_word_o, cmd_code_o, page_o, wdata_o} = {1'b1, w, d, c, p, wd};
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    wdata_o = ~wdata_o;
    rd = rdata_i;
    err = rsp_err_i | !rsp_valid_i;
  endtask : xfer
endmodule : psc_host_model
`default_nettype wire

//--- dv/tb.sv
/*
  Testbench for psc_shed_ctrl with drop delay 8.
  Assumes the checker binds itself.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, cmd_valid_i, cmd_write_i, cmd_word_i, rsp_valid_o, rsp_err_o, e;
  logic [7:0] cmd_code_i, page_i;
  psc_word_t wdata_i, rdata_o, ramp_cfg_a_o, ramp_cfg_b_o, r;
  psc_amp_t pk_a = 0, av_a = 200, pk_b = 0, av_b = 200;
  psc_cnt_t mx_a = 4, mx_b = 2;
  psc_mask_t phase_en_a_o, phase_en_b_o;
  int bad_count = 0, checks_done = 0, cyc = 0;
  always #2 clk_i = ~clk_i;
  psc_shed_ctrl #(.DROP_DELAY_CYC(8)) dut (.clk_i, .sys_rst_i, .cmd_valid_i, .cmd_write_i,
    .cmd_word_i, .cmd_code_i, .page_i, .wdata_i, .peak_cur_a_i(pk_a), .avg_cur_a_i(av_a),
    .max_phases_a_i(mx_a), .peak_cur_b_i(pk_b), .avg_cur_b_i(av_b), .max_phases_b_i(mx_b),
    .rsp_valid_o, .rsp_err_o, .rdata_o, .phase_en_a_o, .phase_en_b_o, .ramp_cfg_a_o,
    .ramp_cfg_b_o);
  psc_host_model host (.clk_i, .rsp_valid_i(rsp_valid_o), .rsp_err_i(rsp_err_o),
    .rdata_i(rdata_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
    .cmd_word_o(cmd_word_i), .cmd_code_o(cmd_code_i), .page_o(page_i), .wdata_o(wdata_i));
  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic op(input logic w, d, input logic [7:0] c, p, input psc_word_t wd, x, input logic ee);
    host.xfer(w, d, c, p, wd, r, e);
    chk(16'(e), 16'(ee));
    if (!w && !ee) chk(r, x);
  endtask : op
  task automatic t_regs;
    op(0, 1, 8'hDE, 8'h00, 0, 16'h5580, 0);
    op(0, 1, 8'hDF, 8'h01, 0, 16'h2AAB, 0);
    op(0, 0, 8'hDE, 8'h00, 0, 0, 1);
    op(1, 0, 8'hDE, 8'h00, 16'h0000, 0, 1);
    op(0, 1, 8'h99, 8'h00, 0, 0, 1);
    op(1, 1, 8'hDE, 8'hFF, 0, 0, 1);
    op(1, 1, 8'hDE, 8'h01, 16'h0000, 0, 0);
    op(0, 1, 8'hDE, 8'h01, 0, 16'h0000, 0);
    chk(ramp_cfg_a_o, 16'h5580);
    chk(ramp_cfg_b_o, 16'h0000);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_shed;
    op(1, 1, 8'hDF, 8'h00, 16'h0022, 0, 0);
    pk_a = 16;
    repeat (2) @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h0003);
    chk(16'(phase_en_b_o), 16'h0003);
    pk_a = 27;
    repeat (2) @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h0003);
    pk_a = 28;
    @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h0007);
    pk_a = 0;
    av_a = 19;
    repeat (7) @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h0007);
    av_a = 20;
    @(negedge clk_i);
    av_a = 19;
    repeat (7) @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h0007);
    repeat (2) @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h0003);
    pk_a = 200;
    @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h0007);
    @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h000F);
    pk_a = 0;
    op(1, 1, 8'hDE, 8'h00, 16'h5500, 0, 0);
    mx_a = 6;
    repeat (2) @(negedge clk_i);
    chk(16'(phase_en_a_o), 16'h003F);
    $display("t_shed done");
  endtask : t_shed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 0;
    t_regs();
    t_shed();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
